// ---- dv/sfpb_top_tb.sv ----
// Self-checking bench for the serial free protocol buffer engine.
// Assumes the register map of the package and a baud divisor of 4, five clocks a bit.
`timescale 1ns/1ps
module sfpb_top_tb
   import sfpb_pkg::*;
;
   logic        i_sys_clk = 1'b0;
   logic        i_rst     = 1'b1;
   logic [15:0] i_addr    = 16'h0000;
   logic [15:0] i_wdata   = 16'h0000;
   logic        i_wr      = 1'b0;
   logic        i_rd      = 1'b0;
   logic [15:0] o_rdata;
   logic        rxd;
   logic        o_txd;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   always #2.5 i_sys_clk = ~i_sys_clk;
   sfpb_top i_sfpb_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(o_txd));
   sfpb_uart_model i_sfpb_uart_model (.i_sys_clk(i_sys_clk), .i_txd(o_txd), .o_rxd(rxd));
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // The ceiling leaves ample slack over the fewer than two thousand cycles the tests need.
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(posedge i_sys_clk);
      d = o_rdata;
   endtask
   task automatic rd_check(input string name, input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      bus_rd(a, d);
      check(name, d, exp);
   endtask
   task automatic send(input logic [7:0] b);
      i_sfpb_uart_model.send_byte(b);
      repeat (10) @(posedge i_sys_clk);
   endtask
   task automatic send_f(input logic [10:0] f);
      i_sfpb_uart_model.send_frame(f);
      repeat (10) @(posedge i_sys_clk);
   endtask
   task automatic wait_tx(input int n);
      logic [15:0] d;
      for (int i = 0; i < 200; i++) begin
         repeat (10) @(posedge i_sys_clk);
         bus_rd(TX_CNT_OFS, d);
         if (d === 16'h0000) break;
      end
      check("send count", d, 16'h0000);
      check("sent bytes", 16'(i_sfpb_uart_model.rx_q.size()), 16'(n));
   endtask
   task automatic test_rx_append();
      bus_wr(RX_CNT_OFS, 16'h0000);
      for (int i = 0; i < 4; i++) send(8'h34 + 8'(i));
      rd_check("rx count", RX_CNT_OFS, 16'h0004);
      rd_check("rx word1", RX_BUF_OFS, 16'h3534);
      rd_check("rx word2", 16'h0002, 16'h3736);
      send(8'h38);
      send(8'h39);
      rd_check("rx count", RX_CNT_OFS, 16'h0006);
      rd_check("rx word3", 16'h0003, 16'h3938);
      $display("test rx append done");
   endtask
   task automatic test_rx_wrap();
      bus_wr(CFG_RX_MAX, 16'h0004);
      bus_wr(RX_CNT_OFS, 16'h0000);
      for (int i = 0; i < 5; i++) send(8'ha0 + 8'(i));
      rd_check("wrap count", RX_CNT_OFS, 16'h0001);
      rd_check("wrap word1", RX_BUF_OFS, 16'ha1a4);
      bus_wr(CFG_RX_MAX, MAX_LEN_DEF);
      $display("test rx wrap done");
   endtask
   task automatic test_rx_errors();
      bus_wr(RX_CNT_OFS, 16'h0000);
      send_f({1'b1, 1'b1, 8'h55, 1'b0});
      rd_check("parity flag", STAT_ADDR, 16'h0002);
      send_f({1'b0, 1'b0, 8'h55, 1'b0});
      rd_check("frame flag", STAT_ADDR, 16'h0006);
      rd_check("bad dropped", RX_CNT_OFS, 16'h0000);
      bus_wr(STAT_ADDR, 16'h0006);
      rd_check("flag clear", STAT_ADDR, 16'h0000);
      bus_wr(CFG_FMT, {12'h000, 1'b0, PAR_ODD, 1'b0});
      send_f({1'b1, 1'b1, 8'h55, 1'b0});
      rd_check("odd count", RX_CNT_OFS, 16'h0001);
      rd_check("odd byte", RX_BUF_OFS, 16'ha155);
      bus_wr(CFG_FMT, {12'h000, FMT_DEF});
      $display("test rx errors done");
   endtask
   task automatic test_tx(input logic [15:0] max, input logic [15:0] cnt, input int n);
      bus_wr(CFG_TX_MAX, max);
      bus_wr(TX_BUF_OFS, 16'h4241);
      bus_wr(16'h012e, 16'h0043);
      bus_wr(TX_CNT_OFS, cnt);
      wait_tx(n);
      for (int i = 0; i < n; i++) begin
         check("tx byte", {8'h00, i_sfpb_uart_model.rx_q.pop_front()}, 16'h0041 + 16'(i));
      end
      $display("test tx done");
   endtask
   task automatic test_area();
      logic [15:0] d;
      bus_wr(CFG_AREA, 16'h0001);
      bus_wr(16'h0200, 16'h0000);
      send(8'h61);
      rd_check("sys count", 16'h0200, 16'h0001);
      rd_check("unmapped", 16'h0900, 16'h0000);
      bus_rd(16'h0201, d);
      check("sys byte", d & 16'h00ff, 16'h0061);
      $display("test area done");
   endtask
   initial begin
      repeat (6) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      bus_wr(CFG_BAUD, 16'h0004);
      test_rx_append();
      test_rx_wrap();
      test_rx_errors();
      test_tx(MAX_LEN_DEF, 16'h0003, 3);
      test_tx(16'h0002, 16'h0005, 2);
      test_area();
      summarize();
   end
endmodule

// ---- dv/sfpb_uart_model.sv ----
// Serial partner: sends frames to the block and collects frames from it.
// Assumes 8 data bits, even parity, one stop bit and a bit time of P_BIT clocks.
`timescale 1ns/1ps
module sfpb_uart_model #(
   parameter int P_BIT = 5
) (
   input  wire logic i_sys_clk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   logic [7:0] rx_q[$];
   logic [7:0] rx_byte;
   initial begin
      o_rxd = 1'b1;
   end
   task automatic send_byte(input logic [7:0] b);
      send_frame({1'b1, ^b, b, 1'b0});
   endtask
   // Any frame, bad parity or stop too; the line is left idle high so a low stop bit cannot fake a start.
   task automatic send_frame(input logic [10:0] f);
      for (int i = 0; i < 11; i++) begin
         @(posedge i_sys_clk);
         o_rxd <= f[i];
         repeat (P_BIT - 1) @(posedge i_sys_clk);
      end
      @(posedge i_sys_clk);
      o_rxd <= 1'b1;
   endtask
   // Samples near mid-bit; parity and stop are skipped since the bench judges the data only.
   always begin
      @(negedge i_txd);
      repeat (2) @(posedge i_sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (P_BIT) @(posedge i_sys_clk);
         rx_byte[i] = i_txd;
      end
      repeat (2 * P_BIT) @(posedge i_sys_clk);
      rx_q.push_back(rx_byte);
   end
endmodule

// ---- hdl/sfpb_mem.sv ----
// Word memory holding both areas, with byte-lane writes and a registered read.
// Assumes the caller arbitrates so at most one writer and one reader act per cycle.
`timescale 1ns/1ps
module sfpb_mem
   import sfpb_pkg::*;
(
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   // Write port
   input  wire logic              i_we,
   input  wire logic [1:0]        i_wbe,
   input  wire logic [MEM_AW-1:0] i_waddr,
   input  wire logic [DW-1:0]     i_wdata,
   // Read port, with a bypass word that replaces the memory data
   input  wire logic              i_re,
   input  wire logic [MEM_AW-1:0] i_raddr,
   input  wire logic              i_byp,
   input  wire logic [DW-1:0]     i_byp_data,
   output logic      [DW-1:0]     o_rdata
);
   logic [DW-1:0] mem [0:(1<<MEM_AW)-1];

   always_ff @(posedge i_sys_clk) begin
      if (i_we && i_wbe[0]) begin
         mem[i_waddr][7:0] <= i_wdata[7:0];
      end
      if (i_we && i_wbe[1]) begin
         mem[i_waddr][15:8] <= i_wdata[15:8];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else if (i_byp) begin
         o_rdata <= i_byp_data;
      end else if (i_re) begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule

// ---- hdl/sfpb_pkg.sv ----
// Constants shared by the serial free protocol buffer engine.
// Assumes a 200 MHz system clock and word-indexed register bus addresses.
package sfpb_pkg;
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned DEF_BAUD      = 9600;
   localparam logic [15:0] DEF_BAUD_DIV  = 16'(CLK_HZ / DEF_BAUD);
   localparam int          MEM_AW        = 10;
   localparam int          OFS_W         = 9;
   localparam int          DW            = 16;
   localparam int          FRAME_W       = 12;
   // Default word offsets inside the selected area.
   localparam logic [8:0]  RX_CNT_OFS    = 9'h000;
   localparam logic [8:0]  RX_BUF_OFS    = 9'h001;
   localparam logic [8:0]  TX_CNT_OFS    = 9'h12c;
   localparam logic [8:0]  TX_BUF_OFS    = 9'h12d;
   localparam logic [15:0] MAX_LEN_DEF   = 16'h0100;
   localparam logic        AREA_WORD     = 1'b0;
   localparam logic        AREA_SYS      = 1'b1;
   // Configuration and status words, above the memory window.
   localparam logic [15:0] CFG_AREA      = 16'h0800;
   localparam logic [15:0] CFG_RX_CNT    = 16'h0801;
   localparam logic [15:0] CFG_RX_BUF    = 16'h0802;
   localparam logic [15:0] CFG_RX_MAX    = 16'h0803;
   localparam logic [15:0] CFG_TX_CNT    = 16'h0804;
   localparam logic [15:0] CFG_TX_BUF    = 16'h0805;
   localparam logic [15:0] CFG_TX_MAX    = 16'h0806;
   localparam logic [15:0] CFG_BAUD      = 16'h0807;
   localparam logic [15:0] CFG_FMT       = 16'h0808;
   localparam logic [15:0] STAT_ADDR     = 16'h0809;
   localparam logic [15:0] MEM_TOP       = 16'h0400;
   // Format word: bit 0 seven data bits, bits 2:1 parity, bit 3 two stop bits.
   localparam int          FMT_B7        = 0;
   localparam int          FMT_PAR_LO    = 1;
   localparam int          FMT_STOP2     = 3;
   localparam logic [1:0]  PAR_NONE      = 2'h0;
   localparam logic [1:0]  PAR_EVEN      = 2'h1;
   localparam logic [1:0]  PAR_ODD       = 2'h2;
   localparam logic [3:0]  FMT_DEF       = 4'h2;
   // Status word bits.
   localparam int          ST_BUSY       = 0;
   localparam int          ST_PERR       = 1;
   localparam int          ST_FERR       = 2;
   localparam logic [1:0]  BE_LO         = 2'h1;
   localparam logic [1:0]  BE_HI         = 2'h2;
   localparam logic [3:0]  BITS_8        = 4'h8;
   localparam logic [3:0]  BITS_7        = 4'h7;
endpackage

// ---- hdl/sfpb_top.sv ----
// Buffer engine for a serial port running a free, user-defined protocol.
// Assumes a register bus master with one-cycle strobes and an asynchronous serial line.
`timescale 1ns/1ps
module sfpb_top
   import sfpb_pkg::*;
#(
   parameter logic P_SYS_AREA_EN = 1'b1
) (
   // Clock and reset
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst,
   // Register bus
   input  wire logic [15:0]   i_addr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic          i_wr,
   input  wire logic          i_rd,
   output logic      [DW-1:0] o_rdata,
   // Serial line
   input  wire logic          i_rxd,
   output logic               o_txd
);
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_BITS  = 3'b100
   } sfpb_rx_t;
   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_FETCH = 4'b0010,
      TX_WAIT  = 4'b0100,
      TX_SHIFT = 4'b1000
   } sfpb_tx_t;

   // Parity bit for the data bits in use.
   function automatic logic par_bit(input logic [7:0] d, input logic [3:0] fmt);
      logic [7:0] m;
      m = fmt[FMT_B7] ? {1'b0, d[6:0]} : d;
      return (^m) ^ (fmt[FMT_PAR_LO+1 -: 2] == PAR_ODD);
   endfunction

   function automatic logic [3:0] data_bits(input logic [3:0] fmt);
      return fmt[FMT_B7] ? BITS_7 : BITS_8;
   endfunction

   function automatic logic par_on(input logic [3:0] fmt);
      return fmt[FMT_PAR_LO+1 -: 2] != PAR_NONE;
   endfunction

   logic             area_reg;
   logic [8:0]       rx_cnt_ofs_reg, rx_buf_ofs_reg, tx_cnt_ofs_reg, tx_buf_ofs_reg;
   logic [15:0]      rx_max_reg, tx_max_reg, baud_div_reg;
   logic [3:0]       fmt_reg;
   logic [15:0]      rx_cnt_reg, tx_cnt_reg;
   logic             perr_reg, ferr_reg;
   logic [MEM_AW-1:0] rx_cnt_addr, tx_cnt_addr;
   logic             bus_mem, wr_rx_cnt, wr_tx_cnt;

   // The system data area exists only where the product variant provides it.
   logic area_eff;
   assign area_eff    = area_reg & P_SYS_AREA_EN;
   assign rx_cnt_addr = {area_eff, rx_cnt_ofs_reg};
   assign tx_cnt_addr = {area_eff, tx_cnt_ofs_reg};
   assign bus_mem     = i_addr < MEM_TOP;
   assign wr_rx_cnt   = i_wr && bus_mem && (i_addr[MEM_AW-1:0] == rx_cnt_addr);
   assign wr_tx_cnt   = i_wr && bus_mem && (i_addr[MEM_AW-1:0] == tx_cnt_addr);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         area_reg       <= AREA_WORD;
         rx_cnt_ofs_reg <= RX_CNT_OFS;
         rx_buf_ofs_reg <= RX_BUF_OFS;
         tx_cnt_ofs_reg <= TX_CNT_OFS;
         tx_buf_ofs_reg <= TX_BUF_OFS;
         rx_max_reg     <= MAX_LEN_DEF;
         tx_max_reg     <= MAX_LEN_DEF;
         baud_div_reg   <= DEF_BAUD_DIV;
         fmt_reg        <= FMT_DEF;
      end else if (i_wr) begin
         unique case (i_addr)
            CFG_AREA:   area_reg       <= i_wdata[0];
            CFG_RX_CNT: rx_cnt_ofs_reg <= i_wdata[OFS_W-1:0];
            CFG_RX_BUF: rx_buf_ofs_reg <= i_wdata[OFS_W-1:0];
            CFG_RX_MAX: rx_max_reg     <= i_wdata;
            CFG_TX_CNT: tx_cnt_ofs_reg <= i_wdata[OFS_W-1:0];
            CFG_TX_BUF: tx_buf_ofs_reg <= i_wdata[OFS_W-1:0];
            CFG_TX_MAX: tx_max_reg     <= i_wdata;
            CFG_BAUD:   baud_div_reg   <= i_wdata;
            CFG_FMT:    fmt_reg        <= i_wdata[3:0];
            default: ;
         endcase
      end
   end

   // Receive line: two synchroniser stages, then a third stage for edge finding.
   logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_s3_reg <= 1'b1;
      end else begin
         rx_s1_reg <= i_rxd;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
      end
   end

   sfpb_rx_t           rx_state_reg;
   logic [15:0]        rx_tmr_reg;
   logic [3:0]         rx_pos_reg;
   logic [FRAME_W-1:0] rx_frame_reg;
   logic               rx_pend_reg;
   logic [7:0]         rx_byte_reg;
   logic [3:0]         rx_last;
   logic [7:0]         rx_data;
   assign rx_last = data_bits(fmt_reg) + {3'h0, par_on(fmt_reg)} + 4'h1;
   assign rx_data = fmt_reg[FMT_B7] ? {1'b0, rx_frame_reg[7:1]} : rx_frame_reg[8:1];

   // A sample is taken mid-bit: half a bit after the start edge, then every bit time.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_state_reg <= RX_IDLE;
         rx_tmr_reg   <= '0;
         rx_pos_reg   <= '0;
         rx_frame_reg <= '0;
      end else begin
         unique case (rx_state_reg)
            RX_IDLE: begin
               if (rx_s3_reg && !rx_s2_reg) begin
                  rx_state_reg <= RX_START;
                  rx_tmr_reg   <= {1'b0, baud_div_reg[15:1]};
                  rx_frame_reg <= '0;
               end
            end
            RX_START: begin
               if (rx_tmr_reg != '0) begin
                  rx_tmr_reg <= rx_tmr_reg - 16'h1;
               end else if (rx_s2_reg) begin
                  rx_state_reg <= RX_IDLE;
               end else begin
                  rx_state_reg <= RX_BITS;
                  rx_tmr_reg   <= baud_div_reg;
                  rx_pos_reg   <= 4'h1;
               end
            end
            RX_BITS: begin
               if (rx_tmr_reg != '0) begin
                  rx_tmr_reg <= rx_tmr_reg - 16'h1;
               end else begin
                  rx_frame_reg[rx_pos_reg] <= rx_s2_reg;
                  rx_tmr_reg <= baud_div_reg;
                  rx_pos_reg <= rx_pos_reg + 4'h1;
                  if (rx_pos_reg == rx_last) begin
                     rx_state_reg <= RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   logic rx_stop_now, rx_par_bad, rx_commit;
   assign rx_stop_now = (rx_state_reg == RX_BITS) && (rx_tmr_reg == '0) && (rx_pos_reg == rx_last);
   assign rx_par_bad  = par_on(fmt_reg) &&
                        (rx_frame_reg[data_bits(fmt_reg) + 4'h1] != par_bit(rx_data, fmt_reg));

   // A byte waits here only while a bus write holds the memory write port.
   assign rx_commit = rx_pend_reg && !(i_wr && bus_mem);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_pend_reg <= 1'b0;
         rx_byte_reg <= '0;
      end else if (rx_stop_now && rx_s2_reg && !rx_par_bad) begin
         rx_pend_reg <= 1'b1;
         rx_byte_reg <= rx_data;
      end else if (rx_commit) begin
         rx_pend_reg <= 1'b0;
      end
   end

   // Error flags are sticky; a new error wins over a write-one clear.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         perr_reg <= 1'b0;
         ferr_reg <= 1'b0;
      end else begin
         if (rx_stop_now && rx_par_bad) begin
            perr_reg <= 1'b1;
         end else if (i_wr && i_addr == STAT_ADDR && i_wdata[ST_PERR]) begin
            perr_reg <= 1'b0;
         end
         if (rx_stop_now && !rx_s2_reg) begin
            ferr_reg <= 1'b1;
         end else if (i_wr && i_addr == STAT_ADDR && i_wdata[ST_FERR]) begin
            ferr_reg <= 1'b0;
         end
      end
   end

   // A software write and a byte in the same cycle: the byte counts on top of the write.
   logic [15:0]       rx_base, rx_idx;
   logic [MEM_AW-1:0] rx_waddr;
   assign rx_base  = wr_rx_cnt ? i_wdata : rx_cnt_reg;
   assign rx_idx   = (rx_base >= rx_max_reg) ? 16'h0 : rx_base;
   assign rx_waddr = {area_eff, rx_buf_ofs_reg + rx_idx[OFS_W:1]};

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_cnt_reg <= '0;
      end else if (rx_commit) begin
         rx_cnt_reg <= rx_idx + 16'h1;
      end else if (wr_rx_cnt) begin
         rx_cnt_reg <= i_wdata;
      end
   end

   sfpb_tx_t           tx_state_reg;
   logic [15:0]        tx_len_reg, tx_idx_reg, tx_tmr_reg;
   logic [3:0]         tx_left_reg;
   logic [FRAME_W-1:0] tx_frame_reg;
   logic [DW-1:0]      mem_rdata;
   logic               tx_fetch, tx_done;
   logic [7:0]         tx_byte;
   logic [FRAME_W-1:0] tx_build;
   logic [3:0]         tx_bits;

   assign tx_fetch = (tx_state_reg == TX_FETCH) && !i_rd;
   assign tx_byte  = tx_idx_reg[0] ? mem_rdata[15:8] : mem_rdata[7:0];
   assign tx_bits  = data_bits(fmt_reg) + {3'h0, par_on(fmt_reg)} + {3'h0, fmt_reg[FMT_STOP2]} + 4'h2;
   assign tx_done  = (tx_state_reg == TX_SHIFT) && (tx_tmr_reg == '0) && (tx_left_reg == 4'h1) &&
                     (tx_idx_reg + 16'h1 == tx_len_reg);

   // Frame is start bit, data LSB first, optional parity, then stop bits.
   always_comb begin
      tx_build = '1;
      tx_build[0] = 1'b0;
      if (fmt_reg[FMT_B7]) begin
         tx_build[7:1] = tx_byte[6:0];
      end else begin
         tx_build[8:1] = tx_byte;
      end
      if (par_on(fmt_reg)) begin
         tx_build[data_bits(fmt_reg) + 4'h1] = par_bit(tx_byte, fmt_reg);
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_state_reg <= TX_IDLE;
         tx_len_reg   <= '0;
         tx_idx_reg   <= '0;
         tx_tmr_reg   <= '0;
         tx_left_reg  <= '0;
         tx_frame_reg <= '1;
         o_txd        <= 1'b1;
      end else begin
         unique case (tx_state_reg)
            TX_IDLE: begin
               if (tx_cnt_reg != '0) begin
                  tx_state_reg <= TX_FETCH;
                  tx_len_reg   <= (tx_cnt_reg > tx_max_reg) ? tx_max_reg : tx_cnt_reg;
                  tx_idx_reg   <= '0;
               end
            end
            TX_FETCH: begin
               if (tx_fetch) begin
                  tx_state_reg <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               tx_state_reg <= TX_SHIFT;
               tx_frame_reg <= tx_build;
               tx_left_reg  <= tx_bits;
               tx_tmr_reg   <= baud_div_reg;
               o_txd        <= tx_build[0];
            end
            TX_SHIFT: begin
               if (tx_tmr_reg != '0) begin
                  tx_tmr_reg <= tx_tmr_reg - 16'h1;
               end else if (tx_left_reg != 4'h1) begin
                  tx_frame_reg <= {1'b1, tx_frame_reg[FRAME_W-1:1]};
                  o_txd        <= tx_frame_reg[1];
                  tx_left_reg  <= tx_left_reg - 4'h1;
                  tx_tmr_reg   <= baud_div_reg;
               end else if (tx_done || tx_len_reg == '0) begin
                  tx_state_reg <= TX_IDLE;
               end else begin
                  tx_state_reg <= TX_FETCH;
                  tx_idx_reg   <= tx_idx_reg + 16'h1;
               end
            end
         endcase
      end
   end

   // A software write in the finishing cycle is kept, so a new request is not lost.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_cnt_reg <= '0;
      end else if (wr_tx_cnt) begin
         tx_cnt_reg <= i_wdata;
      end else if (tx_done) begin
         tx_cnt_reg <= '0;
      end
   end

   // Read path: bus reads take the port; counters and registers bypass the memory.
   logic [DW-1:0]     byp_data;
   logic              byp;
   logic [MEM_AW-1:0] rd_addr;
   always_comb begin
      byp      = i_rd;
      byp_data = '0;
      if (bus_mem && i_addr[MEM_AW-1:0] == rx_cnt_addr) begin
         byp_data = rx_cnt_reg;
      end else if (bus_mem && i_addr[MEM_AW-1:0] == tx_cnt_addr) begin
         byp_data = tx_cnt_reg;
      end else if (bus_mem) begin
         byp = 1'b0;
      end else begin
         unique case (i_addr)
            CFG_AREA:   byp_data = {15'h0, area_eff};
            CFG_RX_CNT: byp_data = {7'h0, rx_cnt_ofs_reg};
            CFG_RX_BUF: byp_data = {7'h0, rx_buf_ofs_reg};
            CFG_RX_MAX: byp_data = rx_max_reg;
            CFG_TX_CNT: byp_data = {7'h0, tx_cnt_ofs_reg};
            CFG_TX_BUF: byp_data = {7'h0, tx_buf_ofs_reg};
            CFG_TX_MAX: byp_data = tx_max_reg;
            CFG_BAUD:   byp_data = baud_div_reg;
            CFG_FMT:    byp_data = {12'h0, fmt_reg};
            STAT_ADDR:  byp_data = {13'h0, ferr_reg, perr_reg, tx_state_reg != TX_IDLE};
            default:    byp_data = '0;
         endcase
      end
   end
   assign rd_addr = i_rd ? i_addr[MEM_AW-1:0] : {area_eff, tx_buf_ofs_reg + tx_idx_reg[OFS_W:1]};

   sfpb_mem u_mem (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_we       ((i_wr && bus_mem && !wr_rx_cnt && !wr_tx_cnt) || rx_commit),
      .i_wbe      ((i_wr && bus_mem) ? 2'h3 : (rx_idx[0] ? BE_HI : BE_LO)),
      .i_waddr    ((i_wr && bus_mem) ? i_addr[MEM_AW-1:0] : rx_waddr),
      .i_wdata    ((i_wr && bus_mem) ? i_wdata : {rx_byte_reg, rx_byte_reg}),
      .i_re       (i_rd || tx_fetch),
      .i_raddr    (rd_addr),
      .i_byp      (byp),
      .i_byp_data (byp_data),
      .o_rdata    (mem_rdata)
   );
   assign o_rdata = mem_rdata;

   a_rx_count_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      rx_commit |=> rx_cnt_reg == (($past(rx_base) >= $past(rx_max_reg)) ? 16'h1 : $past(rx_base) + 16'h1))
      else $error("receive count did not step or wrap");
   a_rx_no_selfclear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!rx_commit && !wr_rx_cnt) |=> $stable(rx_cnt_reg))
      else $error("receive count changed without a byte or a write");
   a_rx_lane_order: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (rx_commit && !i_wr) |-> (u_mem.i_wbe == (rx_idx[0] ? BE_HI : BE_LO)))
      else $error("received byte went to the wrong half");
   a_rx_word_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (rx_commit && !i_wr && rx_cnt_reg < rx_max_reg) |->
         u_mem.i_waddr == {area_eff, rx_buf_ofs_reg + rx_cnt_reg[OFS_W:1]})
      else $error("received byte not appended after buffered data");
   a_tx_starts: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (tx_state_reg == TX_IDLE && tx_cnt_reg != '0) |=>
         (tx_state_reg == TX_FETCH) and (i_rd or (##2 !o_txd)))
      else $error("nonzero send count did not start a frame");
   a_tx_self_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (tx_done && !wr_tx_cnt) |=> tx_cnt_reg == '0 && tx_state_reg == TX_IDLE)
      else $error("send count not cleared after sending");
   a_tx_len_cap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (tx_state_reg == TX_IDLE && tx_cnt_reg > tx_max_reg) |=> tx_len_reg == $past(tx_max_reg))
      else $error("send length not capped at maximum");
   a_area_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      rx_waddr[MEM_AW-1] == (P_SYS_AREA_EN ? area_reg : AREA_WORD))
      else $error("system data area used where not available");
   a_tx_line_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (tx_state_reg == TX_IDLE) |-> o_txd)
      else $error("line not idle high between frames");
endmodule
